//--- verilog/rsd_top.sv
// Rail sequence delay timers with APB register access
`timescale 1ns/1ps
module rsd_top #(
  parameter int unsigned HALF_MS_CYCLES = rsd_pkg::STEP_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [rsd_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Enable pin
  input wire logic en_pin_i,
  // Sequenced outputs
  output logic stepdown_a_en_o,
  output logic stepdown_b_en_o,
  output logic linear_a_en_o,
  output logic linear_b_en_o,
  output logic general_output_a_o
);
  import rsd_pkg::*;

  localparam int PRESC_W = (HALF_MS_CYCLES > 1) ? $clog2(HALF_MS_CYCLES) : 1;
  localparam logic [PRESC_W-1:0] PRESC_LAST = PRESC_W'(HALF_MS_CYCLES - 1);

  typedef struct packed {
    logic pin_prev;
    logic [PRESC_W-1:0] presc;
    logic [NUM_CH-1:0][7:0] delay;
    logic start_long;
    logic stop_long;
    logic [NUM_CH-1:0] sw_enable;
    logic [NUM_CH-1:0] pin_control;
    logic [31:0] rdata;
    logic [NUM_CH-1:0] rail;
  } rsd_top_s;

  rsd_top_s st;
  rsd_top_s next_st;

  // Decoded bus and pin events
  logic setup_phase;
  logic access_phase;
  logic aligned;
  logic [7:0] reg_idx;
  logic hit_delay;
  logic hit_config;
  logic hit_control;
  logic hit_status;
  logic mapped;
  logic [2:0] delay_ch;
  logic rise;
  logic fall;
  logic tick;
  logic [NUM_CH-1:0] level;
  logic [NUM_CH-1:0] pending;
  logic [31:0] read_mux;

  // APB phases and word-index decode
  assign setup_phase = psel_i && !penable_i;
  assign access_phase = psel_i && penable_i;
  assign aligned = (paddr_i[1:0] == 2'h0);
  assign reg_idx = 8'(paddr_i[ADDR_W-1:2]);

  // Delay registers are contiguous, so one range check covers all five
  assign hit_delay = aligned && (reg_idx >= IDX_STEPDOWN_A_SEQ_DELAY) &&
    (reg_idx <= IDX_GENERAL_OUTPUT_A_SEQ_DELAY);
  assign hit_config = aligned && (reg_idx == IDX_SEQ_CONFIG);
  assign hit_control = aligned && (reg_idx == IDX_RAIL_CONTROL);
  assign hit_status = aligned && (reg_idx == IDX_RAIL_STATUS);
  assign mapped = hit_delay || hit_config || hit_control || hit_status;
  assign delay_ch = 3'(reg_idx - IDX_STEPDOWN_A_SEQ_DELAY);

  // Zero-wait slave; unmapped or unaligned access answers with an error
  assign pready_o = 1'b1;
  assign pslverr_o = access_phase && !mapped;
  assign prdata_o = st.rdata;

  // Enable-pin edges are taken straight; the pin is synchronous here
  assign rise = en_pin_i && !st.pin_prev;
  assign fall = !en_pin_i && st.pin_prev;

  // One shared timebase, restarted on every edge so all timers align
  assign tick = (st.presc == PRESC_LAST) && !(rise || fall);

  // Read data source for the addressed register
  always_comb begin
    read_mux = 32'h0;
    if (hit_delay) begin
      read_mux = {24'h0, st.delay[delay_ch]};
    end else if (hit_config) begin
      read_mux[START_RANGE_BIT] = st.start_long;
      read_mux[STOP_RANGE_BIT] = st.stop_long;
    end else if (hit_control) begin
      read_mux[SW_ENABLE_LSB +: NUM_CH] = st.sw_enable;
      read_mux[PIN_CONTROL_LSB +: NUM_CH] = st.pin_control;
    end else if (hit_status) begin
      read_mux[STAT_LEVEL_LSB +: NUM_CH] = level;
      read_mux[STAT_PENDING_LSB +: NUM_CH] = pending;
      read_mux[STAT_RAIL_LSB +: NUM_CH] = st.rail;
    end
  end

  // Per-channel delay timers, all fed from the same edges and tick
  generate
    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
      rsd_timer u_timer (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .rise_i(rise),
        .fall_i(fall),
        .tick_i(tick),
        .on_code_i(st.delay[ch][ON_DELAY_LSB +: DELAY_CODE_W]),
        .off_code_i(st.delay[ch][OFF_DELAY_LSB +: DELAY_CODE_W]),
        .on_long_i(st.start_long),
        .off_long_i(st.stop_long),
        .level_o(level[ch]),
        .pending_o(pending[ch])
      );
    end
  endgenerate

  // Next state: pin history, timebase, register writes, read capture, rails
  always_comb begin
    next_st = st;
    next_st.pin_prev = en_pin_i;

    // Timebase restarts on any edge, wraps after one step
    if (rise || fall || tick) begin
      next_st.presc = '0;
    end else begin
      next_st.presc = st.presc + PRESC_W'(1);
    end

    // Read data is captured in setup so the access phase sees a flop
    if (setup_phase && !pwrite_i) begin
      next_st.rdata = read_mux;
    end

    // Writes take effect at the completing access edge only
    if (access_phase && pwrite_i && mapped) begin
      if (hit_delay && pstrb_i[0]) begin
        next_st.delay[delay_ch] = pwdata_i[7:0];
      end
      if (hit_config && pstrb_i[0]) begin
        next_st.start_long = pwdata_i[START_RANGE_BIT];
        next_st.stop_long = pwdata_i[STOP_RANGE_BIT];
      end
      if (hit_control && pstrb_i[0]) begin
        next_st.sw_enable = pwdata_i[SW_ENABLE_LSB +: NUM_CH];
      end
      if (hit_control && pstrb_i[1]) begin
        next_st.pin_control = pwdata_i[PIN_CONTROL_LSB +: NUM_CH];
      end
    end

    // Pin control gates the delayed pin with the software bit
    for (int ch = 0; ch < NUM_CH; ch++) begin
      if (st.pin_control[ch]) begin
        next_st.rail[ch] = st.sw_enable[ch] && level[ch];
      end else begin
        next_st.rail[ch] = st.sw_enable[ch];
      end
    end
  end

  // Single state register; reset loads the documented defaults
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      st <= '0;
      st.delay <= DELAY_RST;
      st.sw_enable <= SW_ENABLE_RST;
      st.pin_control <= PIN_CONTROL_RST;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the rail flops
  assign stepdown_a_en_o = st.rail[CH_STEPDOWN_A];
  assign stepdown_b_en_o = st.rail[CH_STEPDOWN_B];
  assign linear_a_en_o = st.rail[CH_LINEAR_A];
  assign linear_b_en_o = st.rail[CH_LINEAR_B];
  assign general_output_a_o = st.rail[CH_GENERAL_A];

endmodule

//--- verilog/rsd_pkg.sv
// Constants, register map and reset values of the rail sequence delay timers
// What this block does
// - Step-down A start-up waits its code in bits 3:0 after enable rise; reset 0x4.
// - Step-down A shut-down waits its code in bits 7:4 after enable fall; reset 0x1.
// - Step-down B start-up waits its code in bits 3:0 after enable rise; reset 0x3.
// - Step-down B shut-down waits its code in bits 7:4 after enable fall; reset 0x1.
// - Linear A start-up waits its code in bits 3:0 after enable rise; reset 0x1.
// - Linear A shut-down waits its code in bits 7:4 after enable fall; reset 0x2.
// - Linear B start-up waits its code in bits 3:0 after enable rise; reset zero.
// - Linear B shut-down waits its code in bits 7:4 after enable fall; reset zero.
// - General output A rises only after its start-up code elapses; field resets 0x5.
// - General output A falls only after its shut-down code elapses; field resets 0x0.
// - Start-up code N gives N half-millisecond steps, or N milliseconds with range set.
// - Shut-down code N gives N half-millisecond steps, or N milliseconds with range set.
// - Configuration bit 6, reset 0, selects the 1 ms start-up step.
// - Configuration bit 5, reset 0, selects the 1 ms shut-down step.
// - Output follows the delayed pin only with pin control set; else software bit alone.
package rsd_pkg;

  // Channel count and order: step-down A, step-down B, linear A, linear B, general output A
  localparam int NUM_CH = 5;
  localparam int CH_STEPDOWN_A = 0;
  localparam int CH_STEPDOWN_B = 1;
  localparam int CH_LINEAR_A = 2;
  localparam int CH_LINEAR_B = 3;
  localparam int CH_GENERAL_A = 4;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_STEPDOWN_A_SEQ_DELAY = 8'h0c;
  localparam logic [7:0] IDX_STEPDOWN_B_SEQ_DELAY = 8'h0d;
  localparam logic [7:0] IDX_LINEAR_A_SEQ_DELAY = 8'h0e;
  localparam logic [7:0] IDX_LINEAR_B_SEQ_DELAY = 8'h0f;
  localparam logic [7:0] IDX_GENERAL_OUTPUT_A_SEQ_DELAY = 8'h10;
  localparam logic [7:0] IDX_SEQ_CONFIG = 8'h13;
  localparam logic [7:0] IDX_RAIL_CONTROL = 8'h20;
  localparam logic [7:0] IDX_RAIL_STATUS = 8'h21;
  localparam int ADDR_W = 10;

  // Delay register fields
  localparam int ON_DELAY_LSB = 0;
  localparam int OFF_DELAY_LSB = 4;
  localparam int DELAY_CODE_W = 4;

  // Configuration register fields
  localparam int START_RANGE_BIT = 6;
  localparam int STOP_RANGE_BIT = 5;

  // Control register fields: software enables low, pin-control bits from bit 8
  localparam int SW_ENABLE_LSB = 0;
  localparam int PIN_CONTROL_LSB = 8;

  // Status register fields
  localparam int STAT_LEVEL_LSB = 0;
  localparam int STAT_PENDING_LSB = 8;
  localparam int STAT_RAIL_LSB = 16;

  // Reset values; delay bytes listed channel 4 down to channel 0
  localparam logic [NUM_CH-1:0][7:0] DELAY_RST = {8'h05, 8'h00, 8'h21, 8'h13, 8'h14};
  localparam logic [NUM_CH-1:0] SW_ENABLE_RST = 5'h17;
  localparam logic [NUM_CH-1:0] PIN_CONTROL_RST = 5'h17;

  // Timebase: one delay step of 0.5 ms at a 10 MHz clock
  localparam real STEP_MS = 0.5;
  localparam real CLK_MHZ = 10.0;
  localparam int STEP_CYCLES = int'($ceil(STEP_MS * 1000.0 * CLK_MHZ));
  localparam int STEP_COUNT_W = 5;

endpackage

//--- verilog/rsd_timer.sv
// One channel's start-up and shut-down delay timer
`timescale 1ns/1ps
module rsd_timer (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // Enable-pin events and shared timebase
  input wire logic rise_i,
  input wire logic fall_i,
  input wire logic tick_i,
  // Delay codes and range selects
  input wire logic [rsd_pkg::DELAY_CODE_W-1:0] on_code_i,
  input wire logic [rsd_pkg::DELAY_CODE_W-1:0] off_code_i,
  input wire logic on_long_i,
  input wire logic off_long_i,
  // Delayed pin state
  output logic level_o,
  output logic pending_o
);
  import rsd_pkg::*;

  typedef struct packed {
    logic level;
    logic pending;
    logic target;
    logic [STEP_COUNT_W-1:0] count;
  } rsd_timer_s;

  rsd_timer_s st;
  rsd_timer_s next_st;
  logic [STEP_COUNT_W-1:0] steps;

  // Step count of the new sequence; the long range doubles each code
  always_comb begin
    if (rise_i) begin
      steps = on_long_i ? {on_code_i, 1'b0} : {1'b0, on_code_i};
    end else begin
      steps = off_long_i ? {off_code_i, 1'b0} : {1'b0, off_code_i};
    end
  end

  // New edge reloads; an edge mid-count simply overrides the old one
  always_comb begin
    next_st = st;
    if (rise_i || fall_i) begin
      next_st.target = rise_i;
      if (steps == '0) begin
        next_st.level = rise_i;
        next_st.pending = 1'b0;
      end else begin
        next_st.pending = 1'b1;
        next_st.count = steps;
      end
    end else if (st.pending && tick_i) begin
      if (st.count == STEP_COUNT_W'(1)) begin
        next_st.level = st.target;
        next_st.pending = 1'b0;
      end else begin
        next_st.count = st.count - STEP_COUNT_W'(1);
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign level_o = st.level;
  assign pending_o = st.pending;

endmodule

//--- sim/rsd_chk.sv
// Port checker for the rail sequence delay timers
`timescale 1ns/1ps
module rsd_chk #(
  parameter int unsigned HALF_MS_CYCLES = 8
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // APB
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [rsd_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Pin and rails
  input wire logic en_pin_i,
  input wire logic stepdown_a_en_o,
  input wire logic stepdown_b_en_o,
  input wire logic linear_a_en_o,
  input wire logic general_output_a_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  // Cycles since a write; a rail may follow a control write two edges late
  logic [2:0] wr_age;
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      wr_age <= 3'h7;
    end else if (psel_i && penable_i && pwrite_i) begin
      wr_age <= 3'h0;
    end else if (wr_age != 3'h7) begin
      wr_age <= wr_age + 3'h1;
    end
  end
  a_ready_access: assert property (psel_i && penable_i |-> pready_o) else $error("ready low");
  a_err_access: assert property (pslverr_o |-> psel_i && penable_i) else $error("stray error");
  // A write leaves the last read data on the bus, so only a read must show zero
  a_err_unmapped: assert property (psel_i && penable_i && paddr_i == 10'h3f0 |->
    pslverr_o && (pwrite_i || prdata_o == 32'h0))
    else $error("unmapped not refused");
  a_read_hold: assert property (psel_i && penable_i |=> $stable(prdata_o)) else $error("read data moved");
  a_rise_sda: assert property ($rose(stepdown_a_en_o) |-> en_pin_i || wr_age < 3'h4)
    else $error("step-down a rose without pin");
  a_fall_lina: assert property ($fell(linear_a_en_o) |-> !en_pin_i || wr_age < 3'h4)
    else $error("linear a fell with pin high");
  a_rise_gen: assert property ($rose(general_output_a_o) |-> $past(en_pin_i) || wr_age < 3'h4)
    else $error("general output rose early");
  a_fall_sdb: assert property ($fell(stepdown_b_en_o) |-> !$past(en_pin_i) || wr_age < 3'h4)
    else $error("step-down b fell early");
  c_err: cover property (pslverr_o);
  c_gen_up: cover property ($rose(general_output_a_o));
  c_sda_down: cover property ($fell(stepdown_a_en_o));
endmodule

bind rsd_top rsd_chk #(.HALF_MS_CYCLES(HALF_MS_CYCLES)) chk (.ref_clk_i, .sys_rst_i, .psel_i, .penable_i,
  .pwrite_i, .paddr_i, .prdata_o, .pready_o, .pslverr_o, .en_pin_i, .stepdown_a_en_o, .stepdown_b_en_o,
  .linear_a_en_o, .general_output_a_o);

//--- sim/test_rail_sequence_delay_timers.sv
// Self-checking bench of the rail sequence delay timers
`timescale 1ns/1ps
module test_rail_sequence_delay_timers;
  import rsd_pkg::*;
  localparam int H = 8;
  localparam logic [ADDR_W-1:0] RST_ADDR[7] = '{10'h30, 10'h34, 10'h38, 10'h3c, 10'h40, 10'h4c, 10'h80};
  localparam logic [31:0] RST_VAL[7] = '{32'h14, 32'h13, 32'h21, 32'h0, 32'h5, 32'h0, 32'h1717};
  // Rows: config, step-down A delay, then rail times; even rows rise, odd rows fall
  localparam logic [7:0] ROW_CFG[6] = '{8'h40, 8'h40, 8'h20, 8'h20, 8'h00, 8'h00};
  localparam logic [7:0] ROW_DLY[6] = '{8'h14, 8'h14, 8'h14, 8'h14, 8'hff, 8'hff};
  localparam int ROW_EXP[6][5] = '{'{66, 50, 18, 2, 82}, '{10, 10, 18, 2, 2}, '{34, 26, 10, 2, 42},
    '{18, 18, 34, 2, 2}, '{122, 26, 10, 2, 42}, '{122, 10, 18, 2, 2}};
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [ADDR_W-1:0] paddr_i = 10'h0;
  logic [31:0] pwdata_i = 32'h0;
  logic [3:0] pstrb_i = 4'hf;
  logic en_pin_i = 1'b0;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic [NUM_CH-1:0] rails;
  logic [NUM_CH-1:0] seen;
  logic [31:0] rd;
  logic err;
  int t[NUM_CH];
  int err_count = 0;
  int n_checks = 0;
  int cycles = 0;

  rsd_top #(.HALF_MS_CYCLES(H)) uut (.ref_clk_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .pstrb_i, .prdata_o, .pready_o, .pslverr_o, .en_pin_i, .stepdown_a_en_o(rails[0]),
    .stepdown_b_en_o(rails[1]), .linear_a_en_o(rails[2]), .linear_b_en_o(rails[3]),
    .general_output_a_o(rails[4]));

  task automatic give_verdict();
    if (err_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    do @(posedge ref_clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  // Move the pin, then note the cycle each rail first reaches the new level
  task automatic edge_run(input logic lvl, input int lim);
    @(posedge ref_clk_i);
    en_pin_i <= lvl;
    seen = 5'h0;
    foreach (t[i]) t[i] = 0;
    for (int c = 1; c <= lim; c++) begin
      @(posedge ref_clk_i);
      #1;
      seen |= rails;
      foreach (t[i]) if (t[i] == 0 && rails[i] === lvl) t[i] = c;
    end
  endtask

  // Free-running clock and hang guard
  initial begin
    forever #50 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      give_verdict();
    end
  end

  // Main sequence
  initial begin
    repeat (4) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    foreach (RST_ADDR[i]) begin
      apb(1'b0, RST_ADDR[i], 32'h0);
      chk("reset value", RST_VAL[i], rd); // to
    end
    apb(1'b1, 10'h80, 32'h1f1f);
    foreach (ROW_CFG[r]) begin
      apb(1'b1, 10'h4c, {24'h0, ROW_CFG[r]});
      apb(1'b1, 10'h30, {24'h0, ROW_DLY[r]});
      edge_run(r % 2 == 0, 130);
      foreach (t[i]) chk("rail delay", ROW_EXP[r][i], t[i]); // to
    end
    apb(1'b0, 10'h30, 32'h0);
    chk("written delay", 32'hff, rd);
    // Pin falls while step-down A start is still pending
    apb(1'b1, 10'h30, 32'h14);
    edge_run(1'b1, 20);
    chk("linear a start", 32'd10, t[CH_LINEAR_A]);
    // Mid-sequence status: both linear rails up, three starts still counting
    apb(1'b0, 10'h84, 32'h0);
    chk("status pending", 32'h000c130c, rd);
    edge_run(1'b0, 60);
    chk("cancelled start", 32'h0, {31'h0, seen[CH_STEPDOWN_A]});
    chk("cancelled general", 32'h0, {31'h0, seen[CH_GENERAL_A]});
    chk("linear a stop", 32'd18, t[CH_LINEAR_A]);
    // Pin control cleared: software bit alone drives the rail
    apb(1'b1, 10'h80, 32'h1);
    repeat (3) @(posedge ref_clk_i);
    #1;
    chk("software rails", 32'h1, {27'h0, rails});
    apb(1'b0, 10'h3f0, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    // Non-default delay and both range bits, so a mid-run reset has something to undo
    apb(1'b1, 10'h30, 32'hff);
    apb(1'b1, 10'h4c, 32'h60);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    #1;
    chk("rails in reset", 32'h0, {27'h0, rails});
    foreach (RST_ADDR[i]) begin
      apb(1'b0, RST_ADDR[i], 32'h0);
      chk("value after reset", RST_VAL[i], rd); // to
    end
    give_verdict();
  end
endmodule
